/* bench/tb_top.sv */
// Purpose: self-checking bench for the bit-rate generator
// Assumes: inputs driven by non-blocking assignment at rising edge
// Notes: outputs sampled at the falling edge
`timescale 1ns/100ps
module tb_top
  import ubrg_pkg::*;
;
  logic clock = 0, reset, reg_write, reg_read, auto_load, rx_busy, idle;
  logic sample_tick, bit_tick, rate_range_select;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, ticks;
  logic [15:0] auto_period;
  int n_errors = 0, comparisons = 0, cyc = 0, n;
  always #5 clock = ~clock;
  ubrg_top i_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .auto_load(auto_load),
    .auto_period(auto_period), .receiver_idle_flag(idle), .sample_tick(sample_tick),
    .bit_tick(bit_tick), .rate_range_select(rate_range_select));
  ubrg_serial_model i_far (.clock(clock), .reset(reset), .sample_tick(sample_tick),
    .bit_tick(bit_tick), .rx_busy(rx_busy), .receiver_idle_flag(idle), .ticks_r(ticks));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic span(input logic b, output int k);
    k = 0;
    while ((b ? bit_tick : sample_tick) !== 1'b1) @(negedge clock);
    do begin
      @(negedge clock);
      k++;
    end while ((b ? bit_tick : sample_tick) !== 1'b1);
  endtask
  task automatic t_period();
    wr(UBRG_OFS_PERIOD_HIGH, 8'h00);
    wr(UBRG_OFS_PERIOD_LOW, 8'h20);
    span(1'b0, n);
    chk(16'(n), 16'h0021);
    $display("period test done");
  endtask
  task automatic t_restart();
    wr(UBRG_OFS_PERIOD_LOW, 8'hC8);
    span(1'b0, n);
    repeat (20) @(negedge clock);
    wr(UBRG_OFS_PERIOD_LOW, 8'h03);
    n = 0;
    while (sample_tick !== 1'b1) begin
      @(negedge clock);
      n++;
    end
    chk(16'(n <= 5), 16'h0001);
    span(1'b0, n);
    chk(16'(n), 16'h0004);
    $display("restart test done");
  endtask
  task automatic t_range();
    wr(UBRG_OFS_CONTROL, 8'h01);
    rd(UBRG_OFS_CONTROL, 8'h01);
    chk(16'(rate_range_select), 16'h0001);
    span(1'b1, n);
    chk(16'(n), 16'h0010);
    wr(UBRG_OFS_CONTROL, 8'h00);
    span(1'b1, n);
    chk(16'(n), 16'h0040);
    $display("range test done");
  endtask
  task automatic t_auto();
    @(posedge clock);
    auto_period <= 16'h0005;
    auto_load <= 1'b1;
    @(posedge clock);
    auto_load <= 1'b0;
    span(1'b0, n);
    chk(16'(n), 16'h0006);
    @(posedge clock);
    rx_busy <= 1'b1;
    rd(UBRG_OFS_STATUS, 8'h00);
    @(posedge clock);
    rx_busy <= 1'b0;
    rd(UBRG_OFS_STATUS, 8'h01);
    $display("auto and status test done");
  endtask
  initial begin
    {reset, reg_write, reg_read, auto_load, rx_busy} = 5'h10;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    auto_period = 16'h0000;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    t_period();
    t_restart();
    t_range();
    t_auto();
    tally_and_finish();
  end
endmodule

/* bench/ubrg_serial_model.sv */
// Purpose: model of the serial logic beside the rate generator
// Assumes: receiver busy level set by the bench
// Notes: counts sample ticks within one bit
`timescale 1ns/100ps
module ubrg_serial_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // From generator
  input wire logic sample_tick,
  input wire logic bit_tick,
  // Receiver state
  input wire logic rx_busy,
  output logic receiver_idle_flag,
  output logic [7:0] ticks_r
);
  assign receiver_idle_flag = !rx_busy;
  always_ff @(posedge clock) begin
    if (reset || bit_tick) begin
      ticks_r <= 8'h00;
    end else if (sample_tick) begin
      ticks_r <= ticks_r + 8'h01;
    end
  end
endmodule

/* verilog/ubrg_counter.sv */
// Purpose: reloadable down counter with expiry strobe
// Assumes: synchronous active-high reset
// Notes: clear takes priority over counting
`timescale 1ns/100ps
module ubrg_counter #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Control
  input wire logic clear,
  input wire logic step,
  input wire logic [W-1:0] load,
  // Result
  output logic expire
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } ubrg_cnt_t;
  ubrg_cnt_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (clear) begin
      s_nxt.cnt = load;
    end else if (step) begin
      if (s_r.cnt == '0) begin
        s_nxt.cnt = load;
      end else begin
        s_nxt.cnt = s_r.cnt - W'(1);
      end
    end
  end
  assign expire = step && !clear && (s_r.cnt == '0);
  always_ff @(posedge clock) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

/* verilog/ubrg_pkg.sv */
// Purpose: constants for the serial port bit-rate generator
// Assumes: 100 MHz system clock, byte-wide register port
// Notes: registers are private offsets on a plain strobe port
// Overview of operation
// - A dedicated 16-bit timer produces bit timing for the serial port.
// - Timer runs freely; period comes from software-written high and low registers.
// - Range bit 1 divides clock by 4(n+1); bit 0 by 16(n+1).
// - Any write to the period pair clears the timer at once.
// - Auto-detect logic may load the period instead of software.
package ubrg_pkg;
  localparam logic [1:0] UBRG_OFS_PERIOD_LOW = 2'h0;
  localparam logic [1:0] UBRG_OFS_PERIOD_HIGH = 2'h1;
  localparam logic [1:0] UBRG_OFS_CONTROL = 2'h2;
  localparam logic [1:0] UBRG_OFS_STATUS = 2'h3;
  localparam int UBRG_BIT_RANGE = 0;
  localparam int UBRG_BIT_IDLE = 0;
  localparam logic [15:0] UBRG_PERIOD_RST = 16'h0000;
  localparam logic [3:0] UBRG_SUB_HIGH = 4'h3;
  localparam logic [3:0] UBRG_SUB_NORMAL = 4'hF;
  typedef enum logic [0:0] {UBRG_RUN, UBRG_RESTART} ubrg_mode_t;
endpackage

/* verilog/ubrg_top.sv */
// Purpose: bit-rate generator for the asynchronous serial port
// Assumes: register strobes one cycle, never together
// Notes: sample_tick at 4 or 16 per bit, bit_tick once per bit
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module ubrg_top
  import ubrg_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Auto-detect load
  input wire logic auto_load,
  input wire logic [15:0] auto_period,
  // Serial logic status
  input wire logic receiver_idle_flag,
  // Timing outputs
  output logic sample_tick,
  output logic bit_tick,
  output logic rate_range_select
);
  typedef struct packed {
    logic [15:0] period;
    logic range;
    logic [3:0] sub;
    logic [7:0] rdata;
    logic tick;
    logic btick;
    ubrg_mode_t mode;
  } ubrg_state_t;
  ubrg_state_t s_r, s_nxt;
  logic period_wr;
  logic expire;
  logic [15:0] load_val;
  // Period writes and auto loads restart the timer
  assign period_wr = (reg_write && (reg_addr == UBRG_OFS_PERIOD_LOW || reg_addr == UBRG_OFS_PERIOD_HIGH))
    || auto_load;
  always_comb begin
    load_val = s_r.period;
    if (auto_load) begin
      load_val = auto_period;
    end else if (reg_write && reg_addr == UBRG_OFS_PERIOD_LOW) begin
      load_val = {s_r.period[15:8], reg_wdata};
    end else if (reg_write && reg_addr == UBRG_OFS_PERIOD_HIGH) begin
      load_val = {reg_wdata, s_r.period[7:0]};
    end
  end
  // Free running period timer
  ubrg_counter #(.W(16)) u_timer (
    .clock(clock),
    .reset(reset),
    .clear(period_wr),
    .step(1'b1),
    .load(load_val),
    .expire(expire)
  );
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    s_nxt.btick = 1'b0;
    s_nxt.rdata = 8'h00;
    s_nxt.period = load_val;
    if (reg_write && reg_addr == UBRG_OFS_CONTROL) begin
      s_nxt.range = reg_wdata[UBRG_BIT_RANGE];
      s_nxt.sub = 4'h0;
    end
    case (s_r.mode)
      UBRG_RUN: begin
        if (period_wr) begin
          s_nxt.sub = 4'h0;
          s_nxt.mode = UBRG_RESTART;
        end else if (expire) begin
          s_nxt.tick = 1'b1;
          // Range sets ticks per bit
          if (s_r.sub >= (s_r.range ? UBRG_SUB_HIGH : UBRG_SUB_NORMAL)) begin
            s_nxt.sub = 4'h0;
            s_nxt.btick = 1'b1;
          end else begin
            s_nxt.sub = s_r.sub + 4'h1;
          end
        end
      end
      UBRG_RESTART: begin
        s_nxt.mode = UBRG_RUN;
      end
      default: begin
        s_nxt.mode = UBRG_RUN;
      end
    endcase
    if (reg_read) begin
      case (reg_addr)
        UBRG_OFS_PERIOD_LOW: s_nxt.rdata = s_r.period[7:0];
        UBRG_OFS_PERIOD_HIGH: s_nxt.rdata = s_r.period[15:8];
        UBRG_OFS_CONTROL: s_nxt.rdata = {7'h00, s_r.range};
        UBRG_OFS_STATUS: s_nxt.rdata = {7'h00, receiver_idle_flag};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      s_r <= '{period: UBRG_PERIOD_RST, range: 1'b0, sub: 4'h0, rdata: 8'h00,
               tick: 1'b0, btick: 1'b0, mode: UBRG_RUN};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign reg_rdata = s_r.rdata;
  assign sample_tick = s_r.tick;
  assign bit_tick = s_r.btick;
  assign rate_range_select = s_r.range;

  property p_tick_follows_expire;
    @(posedge clock) disable iff (reset)
      (expire && !period_wr && s_r.mode == UBRG_RUN) |=> sample_tick;
  endproperty
  a_tick_follows_expire: assert property (p_tick_follows_expire) else $error("tick missing after expiry");
  property p_tick_single;
    @(posedge clock) disable iff (reset) sample_tick |=> !sample_tick || s_r.period == 16'h0000;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick too long");
  property p_write_restart;
    @(posedge clock) disable iff (reset) period_wr |=> !sample_tick && !bit_tick;
  endproperty
  a_write_restart: assert property (p_write_restart) else $error("tick right after period write");
  property p_write_stores;
    @(posedge clock) disable iff (reset)
      (reg_write && reg_addr == UBRG_OFS_PERIOD_LOW && !auto_load) |=> s_r.period[7:0] == $past(reg_wdata);
  endproperty
  a_write_stores: assert property (p_write_stores) else $error("low period not stored");
  property p_auto_stores;
    @(posedge clock) disable iff (reset) auto_load |=> s_r.period == $past(auto_period);
  endproperty
  a_auto_stores: assert property (p_auto_stores) else $error("auto period not stored");
  property p_bit_needs_tick;
    @(posedge clock) disable iff (reset) bit_tick |-> sample_tick;
  endproperty
  a_bit_needs_tick: assert property (p_bit_needs_tick) else $error("bit tick without sample tick");
  property p_high_range_ratio;
    @(posedge clock) disable iff (reset) (rate_range_select && s_r.sub > UBRG_SUB_HIGH) |=> s_r.sub == 4'h0;
  endproperty
  a_high_range_ratio: assert property (p_high_range_ratio) else $error("high range count overrun");
  property p_period_zero_rate;
    @(posedge clock) disable iff (reset)
      (s_r.period == 16'h0000 && $stable(s_r.period) && !period_wr && $past(!period_wr) && s_r.mode == UBRG_RUN
       && $past(s_r.mode) == UBRG_RUN) |=> sample_tick;
  endproperty
  a_period_zero_rate: assert property (p_period_zero_rate) else $error("period zero not every cycle");
endmodule
